// file: rtl/iosd_addr_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "iosd_regs.svh"

module iosd_addr_map
   import iosd_pkg::*;
(
   input wire iosd_op_e op,
   input wire logic [6:0] addr,
   output logic [5:0] ioIdx,
   output logic ioHit,
   output logic isWrite,
   output logic isBit,
   output logic isSkip,
   output logic bitOk
);

   always_comb
   begin
      ioIdx = addr[5:0];
      ioHit = 1'b0;
      isWrite = 1'b0;
      isBit = 1'b0;
      isSkip = 1'b0;
      case (op)
         IO_READ_OP: ioHit = (addr <= `IOSD_IO_TOP);
         IO_WRITE_OP:
         begin
            ioHit = (addr <= `IOSD_IO_TOP);
            isWrite = 1'b1;
         end
         DATA_SPACE_LOAD_OP, DATA_SPACE_STORE_OP:
         begin
            // Data-space view sits 0x20 above the I/O view
            ioHit = (addr >= `IOSD_DS_OFFSET) && (addr <= `IOSD_DS_TOP);
            ioIdx = 6'(addr - `IOSD_DS_OFFSET);
            isWrite = (op == DATA_SPACE_STORE_OP);
         end
         SET_IO_BIT_OP, CLEAR_IO_BIT_OP:
         begin
            ioHit = (addr <= `IOSD_IO_TOP);
            isWrite = 1'b1;
            isBit = 1'b1;
         end
         SKIP_IF_BIT_SET_OP, SKIP_IF_BIT_CLEAR_OP:
         begin
            ioHit = (addr <= `IOSD_IO_TOP);
            isBit = 1'b1;
            isSkip = 1'b1;
         end
         default: ioHit = 1'b0;
      endcase
      bitOk = ioHit && (addr[5:0] <= `IOSD_BIT_TOP);
   end

endmodule
`default_nettype wire

// file: rtl/iosd_bit_merge.sv
`timescale 1ns/1ps
`default_nettype none

module iosd_bit_merge
   import iosd_pkg::*;
(
   input wire logic isBit,
   input wire logic setVal,
   input wire logic [2:0] bitSel,
   input wire logic [7:0] cur,
   input wire logic [7:0] data,
   input wire iosd_mask_s mask,
   output logic [7:0] nxt
);

   logic [7:0] oneHot;
   logic [7:0] wrMask;
   logic [7:0] wrBits;
   logic [7:0] newData;
   logic [7:0] clrBits;

   always_comb
   begin
      oneHot = 8'h01 << bitSel;
      wrMask = mask.impl & ~mask.ro & ~mask.w1c;
      // A bit operation touches only its own bit, never its neighbours
      wrBits = isBit ? (oneHot & wrMask) : wrMask;
      newData = isBit ? {8{setVal}} : data;
      clrBits = (isBit ? oneHot : 8'hff) & mask.w1c & newData;
      nxt = ((cur & ~wrBits) | (newData & wrBits)) & ~clrBits;
   end

endmodule
`default_nettype wire

// file: rtl/iosd_io_space.sv
// How it works
// - I/O read and write use a six-bit address 0x00..0x3F, no offset.
// - Data-space load and store reach each register at its I/O address plus 0x20.
// - Bit set and clear act only on I/O addresses 0x00..0x1F.
// - Bit-test ops in the low range report skip when the bit matches.
// - Status flags clear on writing one; writing zero leaves them.
// - Bit set or clear changes only the addressed bit, no other flag.
`timescale 1ns/1ps
`default_nettype none
`include "iosd_regs.svh"

module iosd_io_space
   import iosd_pkg::*;
#(
   parameter int NUM_LOC = `IOSD_NUM_LOC
)
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic reqValid,
   input wire iosd_op_e reqOp,
   input wire logic [6:0] reqAddr,
   input wire logic [7:0] reqData,
   input wire logic [2:0] reqBit,
   output logic respValid_r,
   output logic [7:0] respData_r,
   output logic skipNext_r,
   output logic respFault_r,
   input wire logic hwValid,
   input wire logic [5:0] hwIdx,
   input wire logic [7:0] hwSet,
   input wire logic [7:0] hwClr,
   input wire logic [7:0] pinAIn,
   input wire logic [7:0] pinBIn,
   input wire logic [7:0] pinDIn,
   output logic periphWrStb_r,
   output logic periphRdStb_r,
   output logic [5:0] periphIdx_r,
   output logic [7:0] periphData_r,
   output logic [7:0] portAOut,
   output logic [7:0] portADir,
   output logic [7:0] portBOut,
   output logic [7:0] portBDir,
   output logic [7:0] portDOut,
   output logic [7:0] portDDir
);

   logic [7:0] locVal_r [NUM_LOC];
   logic [7:0] port_a_pin_input_r;
   logic [7:0] port_b_pin_input_r;
   logic [7:0] port_d_pin_input_r;
   logic [5:0] ioIdx;
   logic ioHit;
   logic isWrite;
   logic isBit;
   logic isSkip;
   logic bitOk;
   logic locOk;
   logic opOk;
   logic wrEn;
   logic rdEn;
   iosd_mask_s mask;
   logic [7:0] curVal;
   logic [7:0] mergeNxt;
   logic bitVal;

   function automatic iosd_mask_s mask_of(input logic [5:0] idx);
      iosd_mask_s m;
      m = '{impl: `IOSD_NONE, ro: `IOSD_NONE, w1c: `IOSD_NONE};
      case (idx)
         `IOSD_A_ANA_DIS: m.impl = `IOSD_M_ANA_DIS;
         `IOSD_A_BAUD_HI: m.impl = `IOSD_M_BAUD_HI;
         `IOSD_A_FRAME_CFG: m.impl = `IOSD_M_FRAME;
         `IOSD_A_CMP_CS: m = '{impl: `IOSD_FULL, ro: `IOSD_RO_CMP, w1c: `IOSD_C_CMP};
         `IOSD_A_BAUD_LO: m.impl = `IOSD_FULL;
         `IOSD_A_SER_CTRL: m = '{impl: `IOSD_FULL, ro: `IOSD_RO_SER_CTRL, w1c: `IOSD_NONE};
         `IOSD_A_SER_STAT:
            m = '{impl: `IOSD_FULL, ro: `IOSD_RO_SER_STAT, w1c: `IOSD_C_SER_STAT};
         `IOSD_A_SER_DATA: m.impl = `IOSD_FULL;
         `IOSD_A_USER_STAT:
            m = '{impl: `IOSD_FULL, ro: `IOSD_RO_USER_STAT, w1c: `IOSD_C_USER_STAT};
         `IOSD_A_USER_DATA: m.impl = `IOSD_FULL;
         `IOSD_A_PD_IN: m = '{impl: `IOSD_M_PD, ro: `IOSD_M_PD, w1c: `IOSD_NONE};
         `IOSD_A_PD_DIR: m.impl = `IOSD_M_PD;
         `IOSD_A_PD_OUT: m.impl = `IOSD_M_PD;
         `IOSD_A_SCR0: m.impl = `IOSD_FULL;
         `IOSD_A_SCR1: m.impl = `IOSD_FULL;
         `IOSD_A_SCR2: m.impl = `IOSD_FULL;
         `IOSD_A_PB_IN: m = '{impl: `IOSD_FULL, ro: `IOSD_FULL, w1c: `IOSD_NONE};
         `IOSD_A_PB_DIR: m.impl = `IOSD_FULL;
         `IOSD_A_PB_OUT: m.impl = `IOSD_FULL;
         `IOSD_A_PA_IN: m = '{impl: `IOSD_M_PA, ro: `IOSD_M_PA, w1c: `IOSD_NONE};
         `IOSD_A_PA_DIR: m.impl = `IOSD_M_PA;
         `IOSD_A_PA_OUT: m.impl = `IOSD_M_PA;
         `IOSD_A_NV_CTRL: m.impl = `IOSD_M_NV_CTRL;
         `IOSD_A_NV_DATA: m.impl = `IOSD_FULL;
         `IOSD_A_NV_ADDR: m.impl = `IOSD_FULL;
         `IOSD_A_PC_MASK: m.impl = `IOSD_FULL;
         `IOSD_A_WD_CS: m = '{impl: `IOSD_FULL, ro: `IOSD_NONE, w1c: `IOSD_C_WD};
         `IOSD_A_T16_FORCE: m.impl = `IOSD_M_T16_FORCE;
         `IOSD_A_PRESC_RST: m.impl = `IOSD_M_PRESC;
         `IOSD_A_T16_CAP_LO: m.impl = `IOSD_FULL;
         `IOSD_A_T16_CAP_HI: m.impl = `IOSD_FULL;
         default: m.impl = `IOSD_NONE;
      endcase
      return m;
   endfunction

   iosd_addr_map u_addr_map (
      .op(reqOp),
      .addr(reqAddr),
      .ioIdx(ioIdx),
      .ioHit(ioHit),
      .isWrite(isWrite),
      .isBit(isBit),
      .isSkip(isSkip),
      .bitOk(bitOk)
   );

   iosd_bit_merge u_bit_merge (
      .isBit(isBit),
      .setVal(reqOp == SET_IO_BIT_OP),
      .bitSel(reqBit),
      .cur(curVal),
      .data(reqData),
      .mask(mask),
      .nxt(mergeNxt)
   );

   // Upper locations belong to other decoders; here they are simply empty
   always_comb
   begin
      mask = mask_of(ioIdx);
      locOk = ioHit && (32'(ioIdx) < NUM_LOC) && (mask.impl != `IOSD_NONE);
      opOk = locOk && (!isBit || bitOk);
      wrEn = reqValid && opOk && isWrite;
      rdEn = reqValid && opOk && !isWrite;
   end

   always_comb
   begin
      curVal = 8'h00;
      if (locOk)
      begin
         case (ioIdx)
            `IOSD_A_PA_IN: curVal = port_a_pin_input_r;
            `IOSD_A_PB_IN: curVal = port_b_pin_input_r;
            `IOSD_A_PD_IN: curVal = port_d_pin_input_r;
            default: curVal = locVal_r[ioIdx];
         endcase
      end
      curVal = curVal & mask.impl;
      bitVal = curVal[reqBit];
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         port_a_pin_input_r <= 8'h00;
         port_b_pin_input_r <= 8'h00;
         port_d_pin_input_r <= 8'h00;
      end
      else
      begin
         port_a_pin_input_r <= pinAIn;
         port_b_pin_input_r <= pinBIn;
         port_d_pin_input_r <= pinDIn;
      end
   end

   // Hardware set is applied last so an event in the clearing cycle survives
   for (genvar g = 0; g < NUM_LOC; g++)
   begin : g_loc
      localparam logic [5:0] LOC = 6'(g);
      localparam iosd_mask_s LOC_MASK = mask_of(LOC);
      logic [7:0] base;
      always_comb
      begin
         base = (wrEn && ioIdx == LOC) ? mergeNxt : locVal_r[g];
         if (hwValid && hwIdx == LOC)
         begin
            base = (base & ~hwClr) | hwSet;
         end
      end
      always_ff @(posedge clk_sys or posedge sys_rst)
      begin
         if (sys_rst)
         begin
            locVal_r[g] <= 8'h00;
         end
         else
         begin
            locVal_r[g] <= base & LOC_MASK.impl;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         respValid_r <= 1'b0;
         respData_r <= 8'h00;
         skipNext_r <= 1'b0;
         respFault_r <= 1'b0;
      end
      else
      begin
         respValid_r <= reqValid;
         respData_r <= (rdEn && !isSkip) ? curVal : 8'h00;
         skipNext_r <= rdEn && isSkip &&
                       (bitVal == (reqOp == SKIP_IF_BIT_SET_OP));
         respFault_r <= reqValid && isBit && ioHit && !bitOk;
      end
   end

   // Peripherals see each accepted access; reserved locations give no strobe
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         periphWrStb_r <= 1'b0;
         periphRdStb_r <= 1'b0;
         periphIdx_r <= 6'h00;
         periphData_r <= 8'h00;
      end
      else
      begin
         periphWrStb_r <= wrEn;
         periphRdStb_r <= rdEn;
         if (reqValid && opOk)
         begin
            periphIdx_r <= ioIdx;
            periphData_r <= wrEn ? mergeNxt : curVal;
         end
      end
   end

   assign portAOut = locVal_r[`IOSD_A_PA_OUT];
   assign portADir = locVal_r[`IOSD_A_PA_DIR];
   assign portBOut = locVal_r[`IOSD_A_PB_OUT];
   assign portBDir = locVal_r[`IOSD_A_PB_DIR];
   assign portDOut = locVal_r[`IOSD_A_PD_OUT];
   assign portDDir = locVal_r[`IOSD_A_PD_DIR];

endmodule
`default_nettype wire

// file: rtl/iosd_pkg.sv
package iosd_pkg;

   typedef enum logic [3:0] {
      NO_OP,
      IO_READ_OP,
      IO_WRITE_OP,
      DATA_SPACE_LOAD_OP,
      DATA_SPACE_STORE_OP,
      SET_IO_BIT_OP,
      CLEAR_IO_BIT_OP,
      SKIP_IF_BIT_SET_OP,
      SKIP_IF_BIT_CLEAR_OP
   } iosd_op_e;

   typedef struct packed {
      logic [7:0] impl;
      logic [7:0] ro;
      logic [7:0] w1c;
   } iosd_mask_s;

endpackage

// file: rtl/iosd_regs.svh
`ifndef IOSD_REGS_SVH
`define IOSD_REGS_SVH

// Address space limits
`define IOSD_IO_TOP 7'h3f
`define IOSD_DS_OFFSET 7'h20
`define IOSD_DS_TOP 7'h5f
`define IOSD_BIT_TOP 6'h1f
`define IOSD_NUM_LOC 38

// Register locations (I/O addresses)
`define IOSD_A_ANA_DIS 6'h01
`define IOSD_A_BAUD_HI 6'h02
`define IOSD_A_FRAME_CFG 6'h03
`define IOSD_A_CMP_CS 6'h08
`define IOSD_A_BAUD_LO 6'h09
`define IOSD_A_SER_CTRL 6'h0a
`define IOSD_A_SER_STAT 6'h0b
`define IOSD_A_SER_DATA 6'h0c
`define IOSD_A_USER_STAT 6'h0e
`define IOSD_A_USER_DATA 6'h0f
`define IOSD_A_PD_IN 6'h10
`define IOSD_A_PD_DIR 6'h11
`define IOSD_A_PD_OUT 6'h12
`define IOSD_A_SCR0 6'h13
`define IOSD_A_SCR1 6'h14
`define IOSD_A_SCR2 6'h15
`define IOSD_A_PB_IN 6'h16
`define IOSD_A_PB_DIR 6'h17
`define IOSD_A_PB_OUT 6'h18
`define IOSD_A_PA_IN 6'h19
`define IOSD_A_PA_DIR 6'h1a
`define IOSD_A_PA_OUT 6'h1b
`define IOSD_A_NV_CTRL 6'h1c
`define IOSD_A_NV_DATA 6'h1d
`define IOSD_A_NV_ADDR 6'h1e
`define IOSD_A_PC_MASK 6'h20
`define IOSD_A_WD_CS 6'h21
`define IOSD_A_T16_FORCE 6'h22
`define IOSD_A_PRESC_RST 6'h23
`define IOSD_A_T16_CAP_LO 6'h24
`define IOSD_A_T16_CAP_HI 6'h25

// Implemented-bit masks
`define IOSD_NONE 8'h00
`define IOSD_FULL 8'hff
`define IOSD_M_ANA_DIS 8'h03
`define IOSD_M_BAUD_HI 8'h0f
`define IOSD_M_FRAME 8'h7f
`define IOSD_M_PD 8'h7f
`define IOSD_M_PA 8'h07
`define IOSD_M_NV_CTRL 8'h3f
`define IOSD_M_T16_FORCE 8'hc0
`define IOSD_M_PRESC 8'h01

// Bits owned by hardware (software writes ignored)
`define IOSD_RO_CMP 8'h20
`define IOSD_RO_SER_CTRL 8'h02
`define IOSD_RO_SER_STAT 8'hbc
`define IOSD_RO_USER_STAT 8'h10

// Write-one-to-clear flag bits
`define IOSD_C_CMP 8'h10
`define IOSD_C_SER_STAT 8'h40
`define IOSD_C_USER_STAT 8'he0
`define IOSD_C_WD 8'h80

`endif

// file: sim/iosd_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module iosd_core_model
   import iosd_pkg::*;
(
   input wire logic clk_sys,
   output logic reqValid,
   output iosd_op_e reqOp,
   output logic [6:0] reqAddr,
   output logic [7:0] reqData,
   output logic [2:0] reqBit,
   input wire logic respValid_r,
   input wire logic [7:0] respData_r,
   input wire logic skipNext_r,
   input wire logic respFault_r
);
   logic [7:0] rdData;
   logic skipSeen;
   logic faultSeen;
   initial
   begin
      reqValid = 1'b0;
      reqOp = NO_OP;
      reqAddr = 7'h00;
      reqData = 8'h00;
      reqBit = 3'h0;
   end
   // An I/O write to reserved 0x00, 0x04..0x07 or 0x1F is sent only when a test asks for a rogue write
   task automatic access(iosd_op_e op, logic [6:0] a, logic [7:0] v, logic [2:0] b,
         logic rogue);
      if (op == IO_WRITE_OP && !rogue && (a inside {7'h00, [7'h04:7'h07], 7'h1f}))
         return;
      @(negedge clk_sys);
      reqValid = 1'b1;
      reqOp = op;
      reqAddr = (op inside {DATA_SPACE_LOAD_OP, DATA_SPACE_STORE_OP}) ? a + 7'h20 : a;
      reqData = v;
      reqBit = b;
      @(negedge clk_sys);
      reqValid = 1'b0;
      // Idle address and data lines toggle so nothing leans on stale values
      reqAddr = ~reqAddr;
      reqData = ~reqData;
      rdData = respData_r;
      skipSeen = skipNext_r;
      faultSeen = respFault_r;
   endtask
endmodule

`default_nettype wire

// file: sim/iosd_io_space_checker.sv
`timescale 1ns/1ps
`default_nettype none

module iosd_io_space_checker
   import iosd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic reqValid,
   input wire iosd_op_e reqOp,
   input wire logic [6:0] reqAddr,
   input wire logic [7:0] reqData,
   input wire logic [2:0] reqBit,
   input wire logic hwValid,
   input wire logic respValid_r,
   input wire logic [7:0] respData_r,
   input wire logic skipNext_r,
   input wire logic respFault_r,
   input wire logic periphWrStb_r,
   input wire logic [7:0] portAOut,
   input wire logic [7:0] portBOut
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   wire logic bitOp = reqValid && (reqOp == SET_IO_BIT_OP || reqOp == CLEAR_IO_BIT_OP);
   wire logic wrOp = reqValid && reqOp == IO_WRITE_OP && !hwValid;

   AST_ANSWER:
      assert property (reqValid |=> respValid_r) else $error("request not answered");
   AST_QUIET:
      assert property (!reqValid |=> !respValid_r && respData_r == 8'h00 && !skipNext_r)
         else $error("answer without request");
   AST_HI_FAULT:
      assert property (bitOp && reqAddr[6:5] == 2'b01 |=> respFault_r && !periphWrStb_r)
         else $error("high bit op not refused");
   AST_LO_OK:
      assert property (bitOp && reqAddr[6:5] == 2'b00 |=> !respFault_r)
         else $error("low bit op refused");
   AST_PORT_A_OUTPUT:
      assert property (wrOp && reqAddr == 7'h1b |=> portAOut == ($past(reqData) & 8'h07))
         else $error("port A write wrong");
   AST_STORE_MAP:
      assert property (reqValid && reqOp == DATA_SPACE_STORE_OP && reqAddr == 7'h38 && !hwValid
         |=> portBOut == $past(reqData)) else $error("store offset wrong");
   AST_RSV_WR:
      assert property (reqValid && reqOp == IO_WRITE_OP && reqAddr inside {[7'h04:7'h07]}
         |=> !periphWrStb_r) else $error("reserved write strobed");
   AST_SET_ONE:
      assert property (reqValid && reqOp == SET_IO_BIT_OP && reqAddr == 7'h18 && !hwValid
         |=> portBOut == ($past(portBOut) | (8'h01 << $past(reqBit))))
         else $error("bit set touched other bits");
   AST_SKIP:
      assert property (skipNext_r |-> respValid_r && !respFault_r) else $error("stray skip");
endmodule

bind iosd_io_space iosd_io_space_checker chk (.*);

`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "iosd_regs.svh"

module testbench;
   import iosd_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic hwValid = 1'b0;
   logic [5:0] hwIdx = 6'h00;
   logic [7:0] hwSet = 8'h00;
   logic [7:0] hwClr = 8'h00;
   logic [7:0] pinAIn = 8'h00;
   logic [7:0] pinBIn = 8'h00;
   logic [7:0] pinDIn = 8'h00;
   logic [7:0] d;
   logic [6:0] a;
   logic [2:0] b;
   wire logic reqValid, respValid_r, skipNext_r, respFault_r, periphWrStb_r, periphRdStb_r;
   wire iosd_op_e reqOp;
   wire logic [6:0] reqAddr;
   wire logic [7:0] reqData, respData_r, portAOut, portBOut, portDOut;
   wire logic [7:0] portADir, portBDir, portDDir, periphData_r;
   wire logic [5:0] periphIdx_r;
   logic [6:0] portAd [6] = '{7'h1b, 7'h1a, 7'h18, 7'h17, 7'h12, 7'h11};
   wire logic [2:0] reqBit;
   int n_errors = 0;
   int n_checks = 0;

   always #2.5 clk_sys = ~clk_sys;

   iosd_io_space dut (.*);
   iosd_core_model core (.*);

   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic io(iosd_op_e op, logic [6:0] ad, logic [7:0] v, logic [2:0] bt);
      core.access(op, ad, v, bt, 1'b0);
   endtask

   function automatic logic [7:0] portMask(logic [6:0] ad);
      return (ad inside {7'h1b, 7'h1a}) ? `IOSD_M_PA :
         (ad inside {7'h12, 7'h11}) ? `IOSD_M_PD : 8'hff;
   endfunction

   function automatic logic [7:0] portSeen(logic [6:0] ad);
      case (ad)
         7'h1b: return portAOut;
         7'h1a: return portADir;
         7'h18: return portBOut;
         7'h17: return portBDir;
         7'h12: return portDOut;
         default: return portDDir;
      endcase
   endfunction

   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      void'($urandom(32'h26a570e9));
      repeat (20) @(negedge clk_sys);
      sys_rst = 1'b0;
      io(IO_READ_OP, 7'h13, 8'h00, 3'h0);
      check("scratch reset", core.rdData, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 12; i++)
      begin
         a = 7'h13 + 7'(i % 3);
         d = 8'($urandom);
         io(IO_WRITE_OP, a, d, 3'h0);
         check("write strobe", {7'h00, periphWrStb_r}, 8'h01);
         check("write index", {2'b00, periphIdx_r}, {1'b0, a});
         check("write data", periphData_r, d);
         io(DATA_SPACE_LOAD_OP, a, 8'h00, 3'h0);
         check("scratch load", core.rdData, d);
         io(IO_READ_OP, a, 8'h00, 3'h0);
         check("scratch read", core.rdData, d);
         check("read strobe", {7'h00, periphRdStb_r}, 8'h01);
      end
      $display("scratch test done");
      for (int i = 0; i < 12; i++)
      begin
         a = portAd[i % 6];
         // Reserved bits are written as zero
         d = 8'($urandom) & portMask(a);
         io(IO_WRITE_OP, a, d, 3'h0);
         check("port out", portSeen(a), d & portMask(a));
         io(IO_READ_OP, a, 8'h00, 3'h0);
         check("port read", core.rdData, d & portMask(a));
      end
      d = 8'($urandom);
      b = 3'($urandom);
      io(DATA_SPACE_STORE_OP, 7'h18, d, 3'h0);
      check("store", portBOut, d);
      io(SET_IO_BIT_OP, 7'h18, 8'h00, b);
      check("bit set", portBOut, d | (8'h01 << b));
      io(CLEAR_IO_BIT_OP, 7'h18, 8'h00, b);
      check("bit clear", portBOut, (d | (8'h01 << b)) & ~(8'h01 << b));
      io(IO_WRITE_OP, 7'h20, 8'h00, 3'h0);
      io(SET_IO_BIT_OP, 7'h20, 8'h00, 3'h0);
      check("high fault", {7'h00, core.faultSeen}, 8'h01);
      io(IO_READ_OP, 7'h20, 8'h00, 3'h0);
      check("high unchanged", core.rdData, 8'h00);
      $display("port and bit test done");
      @(negedge clk_sys);
      pinAIn = 8'($urandom);
      pinBIn = 8'($urandom);
      pinDIn = 8'($urandom);
      repeat (2) @(negedge clk_sys);
      io(IO_READ_OP, 7'h19, 8'h00, 3'h0);
      check("pin A", core.rdData, pinAIn & `IOSD_M_PA);
      for (int i = 0; i < 16; i++)
      begin
         io(i < 8 ? SKIP_IF_BIT_SET_OP : SKIP_IF_BIT_CLEAR_OP, 7'h16, 8'h00, 3'(i));
         check("skip", {7'h00, core.skipSeen}, {7'h00, pinBIn[i % 8] ^ (i >= 8)});
      end
      $display("skip test done");
      @(negedge clk_sys);
      hwValid = 1'b1;
      hwIdx = `IOSD_A_SER_STAT;
      hwSet = `IOSD_C_SER_STAT;
      @(negedge clk_sys);
      hwValid = 1'b0;
      io(IO_WRITE_OP, 7'h0b, 8'h00, 3'h0);
      io(IO_READ_OP, 7'h0b, 8'h00, 3'h0);
      check("flag kept", core.rdData, 8'h40);
      io(SET_IO_BIT_OP, 7'h0b, 8'h00, 3'h0);
      io(IO_READ_OP, 7'h0b, 8'h00, 3'h0);
      check("flag after set", core.rdData, 8'h41);
      io(CLEAR_IO_BIT_OP, 7'h0b, 8'h00, 3'h0);
      io(IO_READ_OP, 7'h0b, 8'h00, 3'h0);
      check("flag after clear", core.rdData, 8'h40);
      hwValid = 1'b1;
      io(IO_WRITE_OP, 7'h0b, 8'h40, 3'h0);
      hwValid = 1'b0;
      io(IO_READ_OP, 7'h0b, 8'h00, 3'h0);
      check("set wins", core.rdData, 8'h40);
      io(IO_WRITE_OP, 7'h0b, 8'h40, 3'h0);
      io(IO_READ_OP, 7'h0b, 8'h00, 3'h0);
      check("flag cleared", core.rdData, 8'h00);
      $display("flag test done");
      core.access(IO_WRITE_OP, 7'h04, 8'hff, 3'h0, 1'b1);
      check("reserved strobe", {7'h00, periphWrStb_r}, 8'h00);
      io(IO_READ_OP, 7'h04, 8'h00, 3'h0);
      check("reserved", core.rdData, 8'h00);
      check("reserved read strobe", {7'h00, periphRdStb_r}, 8'h00);
      io(IO_READ_OP, 7'h1f, 8'h00, 3'h0);
      check("reserved top", core.rdData, 8'h00);
      $display("reserved test done");
      @(negedge clk_sys);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      sys_rst = 1'b0;
      io(IO_READ_OP, 7'h14, 8'h00, 3'h0);
      check("scratch after reset", core.rdData, 8'h00);
      $display("second reset test done");
      stop_test;
   end

   initial
   begin
      repeat (3000) @(posedge clk_sys);
      n_errors++;
      stop_test;
   end
endmodule

`default_nettype wire
